// File: src/bkef_consts.vh
// Constants for the backup event-flag and system-control block.
// Assumes inclusion by bare name from the design files under src/.
`ifndef BKEF_CONSTS_VH
`define BKEF_CONSTS_VH

// ********************************************************************
// Register map
// ********************************************************************
`define BKEF_OFF_MASK        8'h0e
`define BKEF_OFF_FLAG        8'h0f
`define BKEF_OFF_SYSCTL      8'h10
`define BKEF_OFF_SETUP       8'h01
`define BKEF_OFF_STORFN      8'h02
`define BKEF_RST_FLAG        8'h00
`define BKEF_RST_SYSCTL      8'h02
`define BKEF_RST_MASK        8'h00
`define BKEF_RST_SETUP       8'h01
`define BKEF_RST_STORFN      8'h00

// ********************************************************************
// Field positions
// ********************************************************************
`define BKEF_FLG_INOV        7
`define BKEF_FLG_INOC        6
`define BKEF_FLG_STSC        5
`define BKEF_FLG_RBLK        4
`define BKEF_FLG_CMEAS       3
`define BKEF_FLG_ADC         2
`define BKEF_FLG_TWARN       1
`define BKEF_FLG_TSHD        0
`define BKEF_SYS_ADCEN       7
`define BKEF_SYS_RECOV       5
`define BKEF_SYS_TSACT       4
`define BKEF_SYS_STOV        3
`define BKEF_SYS_BFAIL       2
`define BKEF_SYS_PGOOD       1
`define BKEF_SYS_BLKON       0
`define BKEF_SETUP_OVEN      7
`define BKEF_SETUP_ENA       0
`define BKEF_STOR_RBEN       6
`define BKEF_STOR_MEAS       5
`define BKEF_SYS_WMASK       8'hb0

// ********************************************************************
// Timing at 200 MHz (5 ns period)
// ********************************************************************
`define BKEF_CLK_PERIOD_NS   5
`define BKEF_QUAL_DLY_US     1000
`define BKEF_RETRY_MS        300
`define BKEF_QUAL_CYC        ((`BKEF_QUAL_DLY_US * 1000) / `BKEF_CLK_PERIOD_NS)
`define BKEF_RETRY_CYC       ((`BKEF_RETRY_MS * 1000000) / `BKEF_CLK_PERIOD_NS)

`endif

// File: src/bkef_sync3.v
// Three-stage input qualifier for asynchronous level inputs.
// Assumes one clock and a synchronous-released active-low reset.
`timescale 1ns/1ps
`default_nettype none

module bkef_sync3 (
    input  wire       clk_i,
    input  wire       rst_n_i,
    input  wire       d_i,
    output reg        q_o
);
    reg               s1_r;
    reg               s2_r;
    reg               s3_r;

    // ****************************************************************
    // Synchroniser; change accepted once stages two and three agree
    // ****************************************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_o <= s3_r;     // Glitch of one cycle is dropped
            end
        end
    end
endmodule

`default_nettype wire

// File: src/bkef_top.v
// Event flags, interrupt mask and system control of a backup manager,
// with power-on qualification of the input source.
// Assumes analog comparators arrive as asynchronous levels and the
// register port is a simple synchronous address/strobe interface.
`timescale 1ns/1ps
`default_nettype none
`include "bkef_consts.vh"

module bkef_top #(
    parameter QUAL_CYC  = `BKEF_QUAL_CYC,
    parameter RETRY_CYC = `BKEF_RETRY_CYC
) (
    input  wire       mclk_i,
    input  wire       arst_n_i,
    input  wire       in_above_por_i,
    input  wire       in_above_ov_i,
    input  wire       in_overcurrent_i,
    input  wire       stor_short_i,
    input  wire       rev_current_i,
    input  wire       temp_warn_i,
    input  wire       temp_shdn_i,
    input  wire       stor_over_i,
    input  wire       bus_below_fail_i,
    input  wire       meas_done_i,
    input  wire       adc_done_i,
    input  wire       buck_below_off_i,
    input  wire       reg_wr_i,
    input  wire       reg_rd_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    output reg  [7:0] reg_rdata_o,
    output reg        reg_ready_o,
    output reg        int_n_o,
    output reg        supply_on_o,
    output reg        qual_load_o,
    output reg        blk_switch_on_o,
    output reg        buck_mode_o,
    output reg        all_off_o,
    output reg        adc_start_o,
    output reg        meas_start_o
);

    // ****************************************************************
    // States and declarations
    // ****************************************************************
    localparam [4:0] ST_OFF   = 5'b00001;
    localparam [4:0] ST_QUAL  = 5'b00010;
    localparam [4:0] ST_WAIT  = 5'b00100;
    localparam [4:0] ST_ON    = 5'b01000;
    localparam [4:0] ST_BUCK  = 5'b10000;

    reg        rst_m_r;
    reg        rst_n_r;
    wire       por_s;
    wire       ov_s;
    wire       oc_s;
    wire       sc_s;
    wire       rb_s;
    wire       tw_s;
    wire       ts_s;
    wire       sov_s;
    wire       bf_s;
    wire       md_s;
    wire       ad_s;
    wire       bo_s;
    reg  [4:0] st_r;
    reg  [4:0] st_nxt;
    reg [31:0] cnt_r;
    reg [31:0] cnt_nxt;
    reg  [7:0] flag_r;
    reg  [7:0] mask_r;
    reg  [7:0] sysc_r;
    reg  [7:0] setup_r;
    reg  [7:0] storfn_r;
    reg        md_d_r;
    reg        ad_d_r;
    reg  [7:0] flag_set;
    reg  [7:0] flag_clr;
    reg        stov_set;
    reg        bf_set;
    wire       wr_flag;
    wire       wr_sys;
    wire       regs_live;

    // ****************************************************************
    // Reset release through two flops
    // ****************************************************************
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    // ****************************************************************
    // Comparator input qualification
    // ****************************************************************
    bkef_sync3 u_por (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(in_above_por_i), .q_o(por_s));
    bkef_sync3 u_ov  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(in_above_ov_i), .q_o(ov_s));
    bkef_sync3 u_oc  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(in_overcurrent_i), .q_o(oc_s));
    bkef_sync3 u_sc  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(stor_short_i), .q_o(sc_s));
    bkef_sync3 u_rb  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(rev_current_i), .q_o(rb_s));
    bkef_sync3 u_tw  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(temp_warn_i), .q_o(tw_s));
    bkef_sync3 u_ts  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(temp_shdn_i), .q_o(ts_s));
    bkef_sync3 u_sov (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(stor_over_i), .q_o(sov_s));
    bkef_sync3 u_bf  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(bus_below_fail_i), .q_o(bf_s));
    bkef_sync3 u_md  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(meas_done_i), .q_o(md_s));
    bkef_sync3 u_ad  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(adc_done_i), .q_o(ad_s));
    bkef_sync3 u_bo  (.clk_i(mclk_i), .rst_n_i(rst_n_r),
        .d_i(buck_below_off_i), .q_o(bo_s));

    // Registers only answer once the supply is up and sequence done
    assign regs_live = (st_r == ST_ON) || (st_r == ST_BUCK);
    assign wr_flag = reg_wr_i && regs_live &&
                     (reg_addr_i == `BKEF_OFF_FLAG);
    assign wr_sys  = reg_wr_i && regs_live &&
                     (reg_addr_i == `BKEF_OFF_SYSCTL);

    // ****************************************************************
    // Power-on and qualification sequence
    // ****************************************************************
    always @* begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
            ST_OFF: begin
                cnt_nxt = 32'h0000_0000;
                if (por_s) begin
                    st_nxt = ST_QUAL;
                end
            end
            ST_QUAL: begin
                // Source must hold above threshold under load
                if (!por_s || ov_s) begin
                    st_nxt  = ST_WAIT;
                    cnt_nxt = 32'h0000_0000;
                end else if (cnt_r >= QUAL_CYC - 1) begin
                    st_nxt  = ST_ON;
                    cnt_nxt = 32'h0000_0000;
                end else begin
                    cnt_nxt = cnt_r + 32'h0000_0001;
                end
            end
            ST_WAIT: begin
                if (cnt_r >= RETRY_CYC - 1) begin
                    st_nxt  = ST_QUAL;
                    cnt_nxt = 32'h0000_0000;
                end else begin
                    cnt_nxt = cnt_r + 32'h0000_0001;
                end
            end
            ST_ON: begin
                if (ts_s && !sysc_r[`BKEF_SYS_TSACT]) begin
                    st_nxt = ST_BUCK;
                end else if (bf_s || !por_s || rb_s || oc_s) begin
                    st_nxt = ST_BUCK;
                end
            end
            ST_BUCK: begin
                cnt_nxt = 32'h0000_0000;
                if (por_s && !ov_s && !ts_s && !bf_s &&
                    sysc_r[`BKEF_SYS_RECOV]) begin
                    st_nxt = ST_QUAL;
                end else if (bo_s) begin
                    st_nxt = ST_QUAL;
                end
            end
            default: begin
                st_nxt  = ST_OFF;
                cnt_nxt = 32'h0000_0000;
            end
        endcase
        // Hard thermal action wins in every state but off; input collapse wins in every state but buck
        if (ts_s && sysc_r[`BKEF_SYS_TSACT] && st_r != ST_OFF) begin
            st_nxt = ST_OFF;
        end
        if (!por_s && st_r != ST_BUCK) begin
            st_nxt = ST_OFF;
        end
    end

    always @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r  <= ST_OFF;
            cnt_r <= 32'h0000_0000;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ****************************************************************
    // Event sources; hardware set beats host clear
    // ****************************************************************
    always @* begin
        flag_set = 8'h00;
        flag_set[`BKEF_FLG_INOV]  = ov_s &&
            setup_r[`BKEF_SETUP_OVEN];
        flag_set[`BKEF_FLG_INOC]  = oc_s;
        flag_set[`BKEF_FLG_STSC]  = sc_s;
        flag_set[`BKEF_FLG_RBLK]  = rb_s &&
            storfn_r[`BKEF_STOR_RBEN];
        flag_set[`BKEF_FLG_CMEAS] = md_s && !md_d_r;
        flag_set[`BKEF_FLG_ADC]   = ad_s && !ad_d_r;
        flag_set[`BKEF_FLG_TWARN] = tw_s;
        flag_set[`BKEF_FLG_TSHD]  = ts_s;
        flag_clr = wr_flag ? reg_wdata_i : 8'h00;
        stov_set = sov_s;
        bf_set   = bf_s;
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    always @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            flag_r   <= `BKEF_RST_FLAG;
            mask_r   <= `BKEF_RST_MASK;
            sysc_r   <= `BKEF_RST_SYSCTL;
            setup_r  <= `BKEF_RST_SETUP;
            storfn_r <= `BKEF_RST_STORFN;
            md_d_r   <= 1'b0;
            ad_d_r   <= 1'b0;
        end else if (st_r == ST_OFF) begin
            // Defaults restored while the sequence sits in ST_OFF
            flag_r   <= `BKEF_RST_FLAG;
            mask_r   <= `BKEF_RST_MASK;
            sysc_r   <= `BKEF_RST_SYSCTL;
            setup_r  <= `BKEF_RST_SETUP;
            storfn_r <= `BKEF_RST_STORFN;
            md_d_r   <= md_s;
            ad_d_r   <= ad_s;
        end else begin
            md_d_r <= md_s;
            ad_d_r <= ad_s;
            flag_r <= (flag_r & ~flag_clr) | flag_set;
            if (reg_wr_i && regs_live &&
                reg_addr_i == `BKEF_OFF_MASK) begin
                mask_r <= reg_wdata_i;
            end
            if (reg_wr_i && regs_live &&
                reg_addr_i == `BKEF_OFF_SETUP) begin
                setup_r <= reg_wdata_i;
            end
            if (reg_wr_i && regs_live &&
                reg_addr_i == `BKEF_OFF_STORFN) begin
                storfn_r <= reg_wdata_i;
            end
            if (wr_sys) begin
                sysc_r[7] <= reg_wdata_i[7];
                sysc_r[5] <= reg_wdata_i[5];
                sysc_r[4] <= reg_wdata_i[4];
            end
            sysc_r[`BKEF_SYS_STOV] <= (sysc_r[`BKEF_SYS_STOV] &&
                !(wr_sys && reg_wdata_i[`BKEF_SYS_STOV])) ||
                stov_set;
            sysc_r[`BKEF_SYS_BFAIL] <= (sysc_r[`BKEF_SYS_BFAIL] &&
                !(wr_sys && reg_wdata_i[`BKEF_SYS_BFAIL])) ||
                bf_set;
            sysc_r[`BKEF_SYS_PGOOD] <= por_s && !ov_s;
            // Same term as the switch output, so status never lies
            sysc_r[`BKEF_SYS_BLKON] <= (st_nxt == ST_ON) &&
                setup_r[`BKEF_SETUP_ENA];
            sysc_r[6] <= 1'b0;
        end
    end

    // ****************************************************************
    // Outputs: read port, interrupt, sequence controls
    // ****************************************************************
    always @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reg_rdata_o     <= 8'h00;
            reg_ready_o     <= 1'b0;
            int_n_o         <= 1'b1;
            supply_on_o     <= 1'b0;
            qual_load_o     <= 1'b0;
            blk_switch_on_o <= 1'b0;
            buck_mode_o     <= 1'b0;
            all_off_o       <= 1'b1;
            adc_start_o     <= 1'b0;
            meas_start_o    <= 1'b0;
        end else begin
            reg_ready_o <= regs_live;
            if (reg_rd_i && regs_live) begin
                case (reg_addr_i)
                    `BKEF_OFF_FLAG:   reg_rdata_o <= flag_r;
                    `BKEF_OFF_MASK:   reg_rdata_o <= mask_r;
                    `BKEF_OFF_SYSCTL: reg_rdata_o <= sysc_r;
                    `BKEF_OFF_SETUP:  reg_rdata_o <= setup_r;
                    `BKEF_OFF_STORFN: reg_rdata_o <= storfn_r;
                    default:          reg_rdata_o <= 8'h00;
                endcase
            end
            // Mask hides the event from the pin only
            int_n_o <= !(|(flag_r & ~mask_r) ||
                sysc_r[`BKEF_SYS_STOV] ||
                sysc_r[`BKEF_SYS_BFAIL] ||
                !sysc_r[`BKEF_SYS_PGOOD]);
            supply_on_o     <= (st_nxt != ST_OFF);
            qual_load_o     <= (st_nxt == ST_QUAL);
            blk_switch_on_o <= (st_nxt == ST_ON) &&
                setup_r[`BKEF_SETUP_ENA];
            buck_mode_o     <= (st_nxt == ST_BUCK);
            all_off_o       <= (st_nxt == ST_OFF);
            // Start pulses on rising control bits only
            adc_start_o  <= wr_sys && reg_wdata_i[`BKEF_SYS_ADCEN] &&
                !sysc_r[`BKEF_SYS_ADCEN];
            meas_start_o <= reg_wr_i && regs_live &&
                reg_addr_i == `BKEF_OFF_STORFN &&
                reg_wdata_i[`BKEF_STOR_MEAS] &&
                !storfn_r[`BKEF_STOR_MEAS];
        end
    end
endmodule

`default_nettype wire

// File: testbench/bkef_bench.sv
// Self-checking bench for the backup event-flag block.
// Assumes the host model drives the port and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
    n_compared = n_compared + 1; \
    if ((e) !== (g)) begin \
        fails = fails + 1; \
        $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
end
// ********
// Bench
// ********
module bkef_bench;
    localparam QC = 20;
    localparam RC = 50;
    reg         clk = 1'b0;
    reg         arst_n = 1'b0;
    reg         por = 1'b1;
    reg  [7:0]  ev = 8'h00;
    reg         sov = 1'b0;
    reg         bfail = 1'b0;
    reg         bo = 1'b0;
    reg         rd_d = 1'b0;
    reg  [15:0] e;
    reg  [31:0] rv;
    reg  [15:0] q[$];
    integer     fails = 0;
    integer     n_compared = 0;
    integer     cyc = 0;
    integer     n_adc = 0;
    integer     n_meas = 0;
    integer     i;
    wire        hwr, hrd, rdy, int_n, sup, blk, buck, adst, mst, alloff;
    wire [7:0]  addr, wdata, rdata;

    always #2.5 clk = ~clk;

    bkef_top #(.QUAL_CYC(QC), .RETRY_CYC(RC)) u_dut (
        .mclk_i(clk), .arst_n_i(arst_n), .in_above_por_i(por),
        .in_above_ov_i(ev[7]), .in_overcurrent_i(ev[6]),
        .stor_short_i(ev[5]), .rev_current_i(ev[4]), .meas_done_i(ev[3]),
        .adc_done_i(ev[2]), .temp_warn_i(ev[1]), .temp_shdn_i(ev[0]),
        .stor_over_i(sov), .bus_below_fail_i(bfail),
        .buck_below_off_i(bo), .reg_wr_i(hwr), .reg_rd_i(hrd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_ready_o(rdy), .int_n_o(int_n), .supply_on_o(sup),
        .qual_load_o(), .blk_switch_on_o(blk), .buck_mode_o(buck),
        .all_off_o(alloff), .adc_start_o(adst), .meas_start_o(mst)
    );
    bkef_host u_host (
        .clk_i(clk), .ready_i(rdy), .wr_o(hwr), .rd_o(hrd),
        .addr_o(addr), .wdata_o(wdata)
    );

    // Match read results with the oldest note; count pulses; watchdog
    always @(posedge clk) begin
        rd_d <= hrd && rdy;
        n_adc <= n_adc + adst;
        n_meas <= n_meas + mst;
        cyc <= cyc + 1;
        if (rd_d) begin
            e = q.pop_front();
            `CHK("rdata", e[7:0], rdata & e[15:8])
        end
        if (cyc == 20000) begin
            fails = fails + 1;
            complete_run;
        end
    end

    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task rd_reg(input [7:0] a, input [7:0] c, input [7:0] x);
        begin
            q.push_back({c, x & c});
            u_host.acc(1'b0, a, 8'h00);
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        u_host.acc(1'b1, a, d);
    endtask
    task done(input [79:0] s);
        $display("test %0s done", s);
    endtask
    task complete_run;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        rv = $urandom(34);
        tick(3);
        arst_n <= 1'b1;
        rd_reg(8'h0f, 8'hff, 8'h00);
        rd_reg(8'h10, 8'hff, 8'h03);
        rv = $urandom;
        wr_reg(8'h55, rv[7:0]);
        rd_reg(8'h55, 8'hff, 8'h00);
        wr_reg(8'h0e, rv[7:0]);
        rd_reg(8'h0e, 8'hff, rv[7:0]);
        wr_reg(8'h0e, 8'h00);
        done("defaults");
        // Control bits, reserved bit, start edges only on a rise
        wr_reg(8'h10, 8'hff);
        rd_reg(8'h10, 8'hff, 8'hb3);
        wr_reg(8'h10, 8'h80);
        wr_reg(8'h10, 8'h00);
        wr_reg(8'h10, 8'h80);
        wr_reg(8'h02, 8'h60);
        wr_reg(8'h02, 8'h40);
        wr_reg(8'h02, 8'h60);
        wr_reg(8'h02, 8'h40);
        wr_reg(8'h01, 8'h81);
        tick(4);
        `CHK("adc", 2, n_adc)
        `CHK("meas", 2, n_meas)
        sov <= 1'b1;
        tick(10);
        sov <= 1'b0;
        tick(8);
        `CHK("int_n", 1'b0, int_n)
        rd_reg(8'h10, 8'hff, 8'h8b);
        wr_reg(8'h10, 8'h88);
        tick(4);
        `CHK("int_n", 1'b1, int_n)
        rd_reg(8'h10, 8'hff, 8'h83);
        done("control");
        // Each event source in turn; overvoltage last
        for (i = 0; i < 8; i = i + 1) begin
            ev <= 8'h01 << i;
            tick(10);
            `CHK("int_n", 1'b0, int_n)
            if (i == 0)
                `CHK("buck", 1'b1, buck)
            ev <= 8'h00;
            tick(8);
            rd_reg(8'h0f, 8'hff, 8'h01 << i);
            wr_reg(8'h0f, 8'h01 << i);
            rd_reg(8'h0f, 8'hff, 8'h00);
        end
        tick(4);
        `CHK("int_n", 1'b1, int_n)
        done("flags");
        // Masked warning; clear while still active must not win
        wr_reg(8'h0e, 8'h02);
        ev <= 8'h02;
        tick(10);
        `CHK("int_n", 1'b1, int_n)
        wr_reg(8'h0f, 8'h02);
        ev <= 8'h00;
        tick(8);
        rd_reg(8'h0f, 8'hff, 8'h02);
        wr_reg(8'h0f, 8'h02);
        rd_reg(8'h0f, 8'hff, 8'h00);
        done("mask");
        bfail <= 1'b1;
        tick(10);
        bfail <= 1'b0;
        tick(8);
        `CHK("int_n", 1'b0, int_n)
        rd_reg(8'h10, 8'hfc, 8'h84);
        wr_reg(8'h10, 8'h84);
        rd_reg(8'h10, 8'hfc, 8'h80);
        wr_reg(8'h0e, 8'h3c);
        done("bus fail");
        // Input loss, return with overvoltage, then retry
        // Still in buck: storage must also run down before shutdown
        por <= 1'b0;
        bo <= 1'b1;
        tick(12);
        `CHK("supply", 1'b0, sup)
        `CHK("all_off", 1'b1, alloff)
        ev <= 8'h80;
        por <= 1'b1;
        bo <= 1'b0;
        tick(QC + 30);
        `CHK("supply", 1'b1, sup)
        `CHK("switch", 1'b0, blk)
        ev <= 8'h00;
        i = 0;
        while (rdy !== 1'b1 && i < RC + QC + 40) begin
            tick(1);
            i = i + 1;
        end
        `CHK("ready", 1'b1, rdy)
        `CHK("switch", 1'b1, blk)
        rd_reg(8'h0e, 8'hff, 8'h00);
        rd_reg(8'h10, 8'hff, 8'h03);
        rd_reg(8'h01, 8'hff, 8'h01);
        tick(4);
        done("power");
        // Recovery mode set: leave buck once the bus is back
        wr_reg(8'h10, 8'h20);
        bfail <= 1'b1;
        tick(10);
        `CHK("buck", 1'b1, buck)
        bfail <= 1'b0;
        tick(QC + 12);
        `CHK("buck", 1'b0, buck)
        `CHK("switch", 1'b1, blk)
        done("recovery");
        complete_run;
    end
endmodule
`default_nettype wire

// File: testbench/bkef_chk_assertions.sv
// Port-level checker for the backup event-flag block.
// Assumes it is bound to bkef_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module bkef_chk #(
    parameter QUAL_CYC = 20
) (
    input wire       mclk_i,
    input wire       arst_n_i,
    input wire       in_above_por_i,
    input wire       stor_over_i,
    input wire       bus_below_fail_i,
    input wire       reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire       reg_ready_o,
    input wire       int_n_o,
    input wire       supply_on_o,
    input wire       qual_load_o,
    input wire       blk_switch_on_o,
    input wire       adc_start_o,
    input wire       meas_start_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    reg [31:0] qrun_r;
    reg        qld_r;
    // Length of the last stretch with the test load on
    always @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            qrun_r <= 32'h0;
            qld_r  <= 1'b0;
        end else begin
            qld_r <= qual_load_o;
            if (qual_load_o)
                qrun_r <= qld_r ? qrun_r + 32'h1 : 32'h1;
        end
    end
    // Event steps; 8 cycles covers the input qualifier delay
    sequence s_por_low;
        !in_above_por_i [*8];
    endsequence
    sequence s_sys_ev;
        (reg_ready_o && (stor_over_i || bus_below_fail_i)) [*8];
    endsequence
    property p_off;
        s_por_low |-> !supply_on_o && !reg_ready_o;
    endproperty
    property p_blk;
        blk_switch_on_o |-> supply_on_o;
    endproperty
    property p_qual;
        $rose(blk_switch_on_o) |-> qrun_r >= QUAL_CYC - 2;
    endproperty
    property p_rst;
        disable iff (1'b0)
        (!arst_n_i) [*2] |-> int_n_o && !reg_ready_o && !blk_switch_on_o;
    endproperty
    property p_meas;
        meas_start_o |=> !meas_start_o;
    endproperty
    property p_adc;
        adc_start_o |=> !adc_start_o;
    endproperty
    property p_rd;
        !$past(reg_rd_i) && reg_ready_o && $past(reg_ready_o)
            |-> $stable(reg_rdata_o);
    endproperty
    property p_sys;
        s_sys_ev |=> !int_n_o;
    endproperty
    a_off: assert property (p_off) else $error("on below por");
    a_blk: assert property (p_blk) else $error("switch w/o supply");
    a_qual: assert property (p_qual) else $error("short qual");
    a_rst: assert property (p_rst) else $error("reset outputs");
    a_meas: assert property (p_meas) else $error("meas pulse");
    a_adc: assert property (p_adc) else $error("adc pulse");
    a_rd: assert property (p_rd) else $error("rdata moved");
    a_sys: assert property (p_sys) else $error("no sys int");
endmodule

bind bkef_top bkef_chk #(.QUAL_CYC(QUAL_CYC)) u_chk (
    .mclk_i, .arst_n_i, .in_above_por_i, .stor_over_i, .bus_below_fail_i,
    .reg_rd_i, .reg_rdata_o, .reg_ready_o, .int_n_o, .supply_on_o,
    .qual_load_o, .blk_switch_on_o, .adc_start_o, .meas_start_o
);
`default_nettype wire

// File: testbench/bkef_host.sv
// Host model: master of the register strobe port.
// Assumes the bench calls its task and shares the clock.
`timescale 1ns/1ps
`default_nettype none
// ********
// Host
// ********
module bkef_host (
    input  wire       clk_i,
    input  wire       ready_i,
    output reg        wr_o,
    output reg        rd_o,
    output reg  [7:0] addr_o,
    output reg  [7:0] wdata_o
);
    // Idle bus at start
    initial begin
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end
    // One access, held for one edge; waits out power-on first
    task acc(input w, input [7:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            while (ready_i !== 1'b1 && n < 1000) begin
                @(posedge clk_i);
                n = n + 1;
            end
            @(posedge clk_i);
            wr_o    <= w;
            rd_o    <= !w;
            addr_o  <= a;
            wdata_o <= d;
            @(posedge clk_i);
            wr_o    <= 1'b0;
            rd_o    <= 1'b0;
            addr_o  <= ~a; // Released bus shows junk, not old value
            wdata_o <= ~d;
        end
    endtask
endmodule
`default_nettype wire
